/* hdl/pcdf_pkg.sv */
// Constants for the port C / D / F pin function logic.
// Assumes an APB master with 8-bit byte addresses and 32-bit data.
package pcdf_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_PC_DATA  = 6'h30;
    localparam logic [5:0] IDX_PC_DIR   = 6'h32;
    localparam logic [5:0] IDX_PC_FUNC  = 6'h33;
    localparam logic [5:0] IDX_PD_DATA  = 6'h34;
    localparam logic [5:0] IDX_PD_DIR   = 6'h36;
    localparam logic [5:0] IDX_PD_FUNC  = 6'h37;
    localparam logic [5:0] IDX_PF_DATA  = 6'h3C;
    localparam logic [5:0] IDX_PF_DIR   = 6'h3E;
    localparam logic [5:0] IDX_PF_FUNC  = 6'h3F;

    // Implemented bits of each register
    localparam logic [7:0] PC_MASK      = 8'h6B;
    localparam logic [7:0] PC_FN_MASK   = 8'h6A;
    localparam logic [7:0] PD_MASK      = 8'h0F;
    localparam logic [7:0] PF_FN_MASK   = 8'h2D;

    // Pins whose data read shows the pin even in output mode
    localparam logic [7:0] PC_PIN_READ  = 8'h63;
    localparam logic [7:0] PD_PIN_READ  = 8'h03;

    // Values after reset
    localparam logic [7:0] DIR_RST      = 8'h00;
    localparam logic [7:0] FUNC_RST     = 8'h00;
    localparam logic [7:0] LAT_RST      = 8'hFF;
    localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

    // Pin counts
    localparam int PC_PINS = 5;
    localparam int PD_PINS = 4;
    localparam int PF_PINS = 8;
    localparam int ALL_PINS = 17;

    typedef struct packed {
        logic [7:0]  c_dir;
        logic [7:0]  c_fn;
        logic [7:0]  c_lat;
        logic [7:0]  d_dir;
        logic [7:0]  d_fn;
        logic [7:0]  d_lat;
        logic [7:0]  f_dir;
        logic [7:0]  f_fn;
        logic [7:0]  f_lat;
        logic [31:0] rdata;
    } pcdf_state_s;

endpackage

/* hdl/pcdf_pin_cell.sv */
// One pin driver: port latch or alternate output, push-pull or open-drain.
// Assumes the enclosing block works out the mode bits.
`timescale 1ns/1ns
`default_nettype none
module pcdf_pin_cell (
    // Mode
    input  wire logic dir,
    input  wire logic alt_en,
    input  wire logic od_en,
    // Data
    input  wire logic latch,
    input  wire logic alt_val,
    // Pin
    output logic      pin_out,
    output logic      pin_oe
);
    // Open drain only ever pulls low, so the level is released for a 1
    always_comb begin
        if (od_en) begin
            pin_out = 1'b0;
            pin_oe  = ~alt_val;
        end else begin
            pin_out = alt_en ? alt_val : latch;
            pin_oe  = alt_en | dir;
        end
    end
endmodule
`default_nettype wire

/* hdl/pcdf_port_logic.sv */
// Pin function logic for ports C (5 pins), D (4 pins) and F (8 pins).
// Assumes an APB master on core_clk and pin inputs synchronous to it.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - C1,C5,C6 serve interrupts 1-3 or timer outputs
// - C3 serves GPIO or interrupt 0
// - C0 pin always feeds 8-bit timer input 0
// - Listed C/D outputs read pin, not latch
// - C/D output function needs direction and function 1
// - Port D four pins, reset makes inputs
// - D0,D1 feed interrupts 4,5 and captures
// - D2,D3 drive the two timer outputs
// - Port F eight pins, per-bit direction
// - Reset clears F direction/function, latch all ones
// - F0,F3 drive serial transmit when selected
// - F1,F4 always feed serial receive
// - F2,F5 feed CTS or drive serial clock
// - F0,F3 direction/function pick four modes
// - Open drain chosen only by bit pair
module pcdf_port_logic
    import pcdf_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Port C pins: C0, C1, C3, C5, C6
    input  wire logic [4:0]  pc_pin_in,
    output logic      [4:0]  pc_pin_out,
    output logic      [4:0]  pc_pin_oe,
    // Port D pins
    input  wire logic [3:0]  pd_pin_in,
    output logic      [3:0]  pd_pin_out,
    output logic      [3:0]  pd_pin_oe,
    // Port F pins
    input  wire logic [7:0]  pf_pin_in,
    output logic      [7:0]  pf_pin_out,
    output logic      [7:0]  pf_pin_oe,
    // Timer side
    input  wire logic        timer8_out1,
    input  wire logic        timer8_out3,
    input  wire logic        timer16a_out0,
    input  wire logic        timer16b_out0,
    input  wire logic        timer16b_out1,
    output logic             timer8_input0,
    output logic             timer16b_capture_in0,
    output logic             timer16b_capture_in1,
    // Interrupt controller side
    output logic             ext_irq_0,
    output logic             ext_irq_1,
    output logic             ext_irq_2,
    output logic             ext_irq_3,
    output logic             ext_irq_4,
    output logic             ext_irq_5,
    // Serial channel side
    input  wire logic        ser0_transmit,
    input  wire logic        ser1_transmit,
    input  wire logic        ser0_clock_out,
    input  wire logic        ser1_clock_out,
    output logic             ser0_receive,
    output logic             ser1_receive,
    output logic             ser0_cts_clk_in,
    output logic             ser1_cts_clk_in
);
    pcdf_state_s st_r;
    pcdf_state_s st_nxt;

    logic              in_range;
    logic              hit;
    logic [5:0]        idx;
    logic [7:0]        c_pin8;
    logic [7:0]        d_pin8;
    logic [7:0]        c_rd;
    logic [7:0]        d_rd;
    logic [ALL_PINS-1:0] v_dir;
    logic [ALL_PINS-1:0] v_alt;
    logic [ALL_PINS-1:0] v_od;
    logic [ALL_PINS-1:0] v_lat;
    logic [ALL_PINS-1:0] v_val;
    logic [ALL_PINS-1:0] v_out;
    logic [ALL_PINS-1:0] v_oe;

    assign idx = paddr[7:2];

    always_comb begin
        case (idx)
            IDX_PC_DATA, IDX_PC_DIR, IDX_PC_FUNC,
            IDX_PD_DATA, IDX_PD_DIR, IDX_PD_FUNC,
            IDX_PF_DATA, IDX_PF_DIR, IDX_PF_FUNC: in_range = 1'b1;
            default: in_range = 1'b0;
        endcase
    end
    assign hit = in_range & (paddr[1:0] == 2'b00);

    // Zero-wait slave: read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata  = st_r.rdata;

    // Spread pins back onto their register bit positions
    assign c_pin8 = {1'b0, pc_pin_in[4], pc_pin_in[3], 1'b0,
                     pc_pin_in[2], 1'b0, pc_pin_in[1], pc_pin_in[0]};
    assign d_pin8 = {4'h0, pd_pin_in};

    // Latch shows only on outputs without a pin read path
    assign c_rd = PC_MASK & ((c_pin8 & ~(st_r.c_dir & ~PC_PIN_READ))
                  | (st_r.c_lat & st_r.c_dir & ~PC_PIN_READ));
    assign d_rd = PD_MASK & ((d_pin8 & ~(st_r.d_dir & ~PD_PIN_READ))
                  | (st_r.d_lat & st_r.d_dir & ~PD_PIN_READ));

    always_comb begin
        st_nxt = st_r;
        if (psel && !penable) begin
            // Direction and function do not read back, so any
            // read-modify-write would clear them
            st_nxt.rdata = RDATA_RST;
            // Misaligned or unmapped reads return zero, not a neighbour
            if (hit) begin
                case (idx)
                    IDX_PC_DATA: st_nxt.rdata = {24'h0, c_rd};
                    IDX_PD_DATA: st_nxt.rdata = {24'h0, d_rd};
                    IDX_PF_DATA: st_nxt.rdata = {24'h0, pf_pin_in};
                    default:     st_nxt.rdata = RDATA_RST;
                endcase
            end
        end
        if (psel && penable && pwrite && hit) begin
            case (idx)
                IDX_PC_DATA: st_nxt.c_lat = pwdata[7:0] & PC_MASK;
                IDX_PC_DIR:  st_nxt.c_dir = pwdata[7:0] & PC_MASK;
                IDX_PC_FUNC: st_nxt.c_fn  = pwdata[7:0] & PC_FN_MASK;
                IDX_PD_DATA: st_nxt.d_lat = pwdata[7:0] & PD_MASK;
                IDX_PD_DIR:  st_nxt.d_dir = pwdata[7:0] & PD_MASK;
                IDX_PD_FUNC: st_nxt.d_fn  = pwdata[7:0] & PD_MASK;
                IDX_PF_DATA: st_nxt.f_lat = pwdata[7:0];
                IDX_PF_DIR:  st_nxt.f_dir = pwdata[7:0];
                IDX_PF_FUNC: st_nxt.f_fn  = pwdata[7:0] & PF_FN_MASK;
                default:     st_nxt = st_r;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.c_dir <= DIR_RST;
            st_r.c_fn  <= FUNC_RST;
            st_r.c_lat <= LAT_RST & PC_MASK;
            st_r.d_dir <= DIR_RST;
            st_r.d_fn  <= FUNC_RST;
            st_r.d_lat <= LAT_RST & PD_MASK;
            st_r.f_dir <= DIR_RST;
            st_r.f_fn  <= FUNC_RST;
            st_r.f_lat <= LAT_RST;
            st_r.rdata <= RDATA_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Flat pin order: C0 C1 C3 C5 C6, D0..D3, F0..F7
    assign v_dir = {st_r.f_dir, st_r.d_dir[3:0], st_r.c_dir[6],
                    st_r.c_dir[5], st_r.c_dir[3], st_r.c_dir[1],
                    st_r.c_dir[0]};
    assign v_lat = {st_r.f_lat, st_r.d_lat[3:0], st_r.c_lat[6],
                    st_r.c_lat[5], st_r.c_lat[3], st_r.c_lat[1],
                    st_r.c_lat[0]};
    assign v_alt = {2'b00, st_r.f_fn[5], 1'b0, st_r.f_fn[3],
                    st_r.f_fn[2], 1'b0, st_r.f_fn[0],
                    st_r.d_dir[3] & st_r.d_fn[3],
                    st_r.d_dir[2] & st_r.d_fn[2], 2'b00,
                    st_r.c_dir[6] & st_r.c_fn[6],
                    st_r.c_dir[5] & st_r.c_fn[5], 1'b0,
                    st_r.c_dir[1] & st_r.c_fn[1], 1'b0};
    assign v_od  = {4'h0, st_r.f_fn[3] & ~st_r.f_dir[3], 2'b00,
                    st_r.f_fn[0] & ~st_r.f_dir[0], 9'h000};
    assign v_val = {2'b00, ser1_clock_out, 1'b0, ser1_transmit,
                    ser0_clock_out, 1'b0, ser0_transmit,
                    timer16b_out1, timer16b_out0, 2'b00,
                    timer16a_out0, timer8_out3, 1'b0, timer8_out1, 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < ALL_PINS; gi = gi + 1) begin : g_pin
            pcdf_pin_cell u_cell (
                .dir     (v_dir[gi]),
                .alt_en  (v_alt[gi]),
                .od_en   (v_od[gi]),
                .latch   (v_lat[gi]),
                .alt_val (v_val[gi]),
                .pin_out (v_out[gi]),
                .pin_oe  (v_oe[gi])
            );
        end
    endgenerate

    assign pc_pin_out = v_out[4:0];
    assign pc_pin_oe  = v_oe[4:0];
    assign pd_pin_out = v_out[8:5];
    assign pd_pin_oe  = v_oe[8:5];
    assign pf_pin_out = v_out[16:9];
    assign pf_pin_oe  = v_oe[16:9];

    // Interrupt and capture inputs are gated so a GPIO pin cannot raise spurious events; timer and serial inputs are not
    assign timer8_input0 = pc_pin_in[0];
    assign ext_irq_0 = pc_pin_in[2] & st_r.c_fn[3] & ~st_r.c_dir[3];
    assign ext_irq_1 = pc_pin_in[1] & st_r.c_fn[1] & ~st_r.c_dir[1];
    assign ext_irq_2 = pc_pin_in[3] & st_r.c_fn[5] & ~st_r.c_dir[5];
    assign ext_irq_3 = pc_pin_in[4] & st_r.c_fn[6] & ~st_r.c_dir[6];
    assign ext_irq_4 = pd_pin_in[0] & st_r.d_fn[0] & ~st_r.d_dir[0];
    assign ext_irq_5 = pd_pin_in[1] & st_r.d_fn[1] & ~st_r.d_dir[1];
    assign timer16b_capture_in0 = ext_irq_4;
    assign timer16b_capture_in1 = ext_irq_5;
    assign ser0_receive    = pf_pin_in[1];
    assign ser1_receive    = pf_pin_in[4];
    assign ser0_cts_clk_in = pf_pin_in[2];
    assign ser1_cts_clk_in = pf_pin_in[5];

    sequence s_rd_setup(logic [5:0] ix);
        psel && !penable && !pwrite && idx == ix && paddr[1:0] == 2'b00;
    endsequence

    sequence s_wr_access(logic [5:0] ix);
        psel && penable && pwrite && idx == ix && paddr[1:0] == 2'b00;
    endsequence

    property p_c_pin_read;
        @(posedge core_clk) disable iff (!rst_n)
        (s_rd_setup(IDX_PC_DATA) ##0 st_r.c_dir[1])
            |=> prdata[1] == $past(pc_pin_in[1]);
    endproperty
    a_c_pin_read: assert property (p_c_pin_read)
        else $error("Port C bit 1 read did not return pin");

    property p_f_read;
        @(posedge core_clk) disable iff (!rst_n)
        s_rd_setup(IDX_PF_DATA) |=> prdata[7:0] == $past(pf_pin_in);
    endproperty
    a_f_read: assert property (p_f_read)
        else $error("Port F read did not return pins");

    property p_f_dir_write;
        @(posedge core_clk) disable iff (!rst_n)
        s_wr_access(IDX_PF_DIR) |=> st_r.f_dir == $past(pwdata[7:0])
            ##1 pf_pin_oe[7] == st_r.f_dir[7];
    endproperty
    a_f_dir_write: assert property (p_f_dir_write)
        else $error("Port F direction write not applied");

    property p_c_alt_gate;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.c_dir[1] && !st_r.c_fn[1]) |-> pc_pin_out[1] == st_r.c_lat[1];
    endproperty
    a_c_alt_gate: assert property (p_c_alt_gate)
        else $error("Port C alternate output without function bit");

    property p_c_timer_out;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.c_dir[6] && st_r.c_fn[6])
            |-> pc_pin_out[4] == timer16a_out0 && pc_pin_oe[4];
    endproperty
    a_c_timer_out: assert property (p_c_timer_out)
        else $error("Port C bit 6 not driving timer output");

    property p_f_open_drain;
        @(posedge core_clk) disable iff (!rst_n)
        (!st_r.f_dir[0] && st_r.f_fn[0])
            |-> !pf_pin_out[0] && pf_pin_oe[0] == !ser0_transmit;
    endproperty
    a_f_open_drain: assert property (p_f_open_drain)
        else $error("Port F bit 0 open-drain transmit wrong");

    property p_f_push_pull;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.f_dir[3] && st_r.f_fn[3])
            |-> pf_pin_oe[3] && pf_pin_out[3] == ser1_transmit;
    endproperty
    a_f_push_pull: assert property (p_f_push_pull)
        else $error("Port F bit 3 push-pull transmit wrong");

    property p_d_irq;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.d_fn[0] && !st_r.d_dir[0])
            |-> ext_irq_4 == pd_pin_in[0] && !pd_pin_oe[0];
    endproperty
    a_d_irq: assert property (p_d_irq)
        else $error("Port D bit 0 interrupt input not fed");

    property p_d_timer_out;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r.d_dir[2] && st_r.d_fn[2]) |-> pd_pin_out[2] == timer16b_out0;
    endproperty
    a_d_timer_out: assert property (p_d_timer_out)
        else $error("Port D bit 2 not driving timer output");

    property p_rx_feed;
        @(posedge core_clk) disable iff (!rst_n)
        ser0_receive == pf_pin_in[1] && ser1_receive == pf_pin_in[4]
            && timer8_input0 == pc_pin_in[0];
    endproperty
    a_rx_feed: assert property (p_rx_feed)
        else $error("Fixed input routing broken");

    property p_f_clk_out;
        @(posedge core_clk) disable iff (!rst_n)
        st_r.f_fn[5] |-> pf_pin_oe[5] && pf_pin_out[5] == ser1_clock_out;
    endproperty
    a_f_clk_out: assert property (p_f_clk_out)
        else $error("Port F bit 5 serial clock not driven");

endmodule
`default_nettype wire

/* tb/pcdf_board_model.sv */
// Board side of the port pins: external drivers and pull-ups.
// Assumes pins packed as {C(5), D(4), F(8)}.
`timescale 1ns/1ns
`default_nettype none
module pcdf_board_model (
    // Design side
    input  wire logic [16:0] dut_out,
    input  wire logic [16:0] dut_oe,
    // Board side
    input  wire logic [16:0] ext_val,
    input  wire logic [16:0] ext_en,
    output logic      [16:0] wire_lvl
);
    // Pull-up only where nobody drives, so a released pin never holds
    // its last value
    always_comb begin
        for (int i = 0; i < 17; i++) begin
            wire_lvl[i] = dut_oe[i] ? dut_out[i]
                        : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule
`default_nettype wire

/* tb/test_port_c_d_f_pin_function_logic.sv */
// Self-checking bench for the port C/D/F pin function block.
// Assumes the board model resolves every pin level.
`timescale 1ns/1ns
`default_nettype none
module test_port_c_d_f_pin_function_logic;
    import pcdf_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [16:0] ext_val = 17'h0;
    logic [16:0] ext_en = 17'h0;
    logic [4:0]  tmr = 5'h0;
    logic [3:0]  ser = 4'h0;
    logic [31:0] prdata, rdv;
    logic        pready, pslverr, erv, t8in, cap0, cap1;
    logic        rx0, rx1, cts0, cts1;
    logic [5:0]  irq;
    logic [16:0] lvl;
    logic [4:0]  pc_out, pc_oe;
    logic [3:0]  pd_out, pd_oe;
    logic [7:0]  pf_out, pf_oe;
    int          err_total = 0;
    int          comparisons = 0;

    always #50 core_clk = ~core_clk;

    pcdf_port_logic pcdf_port_logic_i (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pc_pin_in(lvl[16:12]),
        .pc_pin_out(pc_out), .pc_pin_oe(pc_oe),
        .pd_pin_in(lvl[11:8]), .pd_pin_out(pd_out), .pd_pin_oe(pd_oe),
        .pf_pin_in(lvl[7:0]), .pf_pin_out(pf_out), .pf_pin_oe(pf_oe),
        .timer8_out1(tmr[0]), .timer8_out3(tmr[1]),
        .timer16a_out0(tmr[2]), .timer16b_out0(tmr[3]),
        .timer16b_out1(tmr[4]), .timer8_input0(t8in),
        .timer16b_capture_in0(cap0), .timer16b_capture_in1(cap1),
        .ext_irq_0(irq[0]), .ext_irq_1(irq[1]), .ext_irq_2(irq[2]),
        .ext_irq_3(irq[3]), .ext_irq_4(irq[4]), .ext_irq_5(irq[5]),
        .ser0_transmit(ser[0]), .ser1_transmit(ser[1]),
        .ser0_clock_out(ser[2]), .ser1_clock_out(ser[3]),
        .ser0_receive(rx0), .ser1_receive(rx1),
        .ser0_cts_clk_in(cts0), .ser1_cts_clk_in(cts1)
    );
    pcdf_board_model pcdf_board_model_i (
        .dut_out({pc_out, pd_out, pf_out}),
        .dut_oe({pc_oe, pd_oe, pf_oe}),
        .ext_val(ext_val), .ext_en(ext_en), .wire_lvl(lvl)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Waits on pready instead of trusting the zero-wait promise
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // Only the watchdog ends a wait that never gets an answer
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        apb(1'b1, {i, 2'h0}, d);
    endtask

    task automatic drive(input logic [16:0] en, input logic [16:0] v);
        @(posedge core_clk);
        ext_en <= en;
        ext_val <= v;
    endtask

    task automatic settle();
        @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic t_reset();
        @(negedge core_clk);
        chk({pf_oe, pf_out}, 16'h00FF);
        chk({pd_oe, pc_oe}, 9'h000);
    endtask

    task automatic t_pf_gpio();
        wr(IDX_PF_DATA, 8'h5A);
        wr(IDX_PF_DIR, 8'h0F);
        drive(17'h000F0, 17'h00030);
        settle();
        chk(pf_oe, 8'h0F);
        apb(1'b0, {IDX_PF_DATA, 2'h0}, 8'h00);
        chk(rdv, 32'h3A);
    endtask

    task automatic t_pf_tx();
        logic [1:0] m;
        logic       tx, eoe, elv;
        drive(17'h0, 17'h0);
        wr(IDX_PF_DATA, 8'h00);
        for (int k = 0; k < 8; k++) begin
            m = k[2:1];
            tx = k[0];
            wr(IDX_PF_DIR, m[0] ? 8'h09 : 8'h00);
            ser[1:0] <= {tx, tx};
            wr(IDX_PF_FUNC, m[1] ? 8'h09 : 8'h00);
            settle();
            eoe = m[0] || !tx && m[1];
            elv = (m == 2'h0) ? 1'b1 : (m == 2'h1) ? 1'b0 : tx;
            chk({pf_oe[3], pf_oe[0]}, {eoe, eoe});
            chk({lvl[3], lvl[0]}, {elv, elv});
            if (m[1]) chk(lvl[0], tx);
        end
    endtask

    task automatic t_pf_serial();
        wr(IDX_PF_DIR, 8'h00);
        ser[3:2] <= 2'h1;
        wr(IDX_PF_FUNC, 8'h24);
        for (int p = 0; p < 2; p++) begin
            drive(17'h00012, p ? 17'h00002 : 17'h00010);
            settle();
            chk({rx1, rx0}, p ? 2'h1 : 2'h2);
            chk({pf_oe[5], pf_oe[2], lvl[5], lvl[2]}, 4'hD);
        end
        wr(IDX_PF_FUNC, 8'h00);
        drive(17'h00024, 17'h00020);
        settle();
        chk({cts1, cts0}, 2'h2);
    endtask

    task automatic t_pc();
        logic [4:0] v;
        wr(IDX_PC_FUNC, 8'h6A);
        for (int p = 0; p < 2; p++) begin
            v = p ? 5'h0D : 5'h12;
            drive(17'h1F000, {v, 12'h000});
            settle();
            chk({irq[3:1], t8in}, {v[4], v[3], v[1], v[0]});
            chk(irq[0], v[2]);
            chk(pc_oe, 5'h00);
        end
        drive(17'h0, 17'h0);
        wr(IDX_PC_DATA, 8'h00);
        wr(IDX_PC_FUNC, 8'h00);
        wr(IDX_PC_DIR, 8'h6B);
        settle();
        chk({irq[3:0], pc_out, pc_oe}, 14'h001F);
        chk(t8in, 1'b0);
        wr(IDX_PC_DIR, 8'h62);
        tmr[2:0] <= 3'h5;
        wr(IDX_PC_FUNC, 8'h62);
        settle();
        chk({pc_out[4:3], pc_out[1]}, 3'h5);
        apb(1'b0, {IDX_PC_DATA, 2'h0}, 8'h00);
        chk(rdv, 32'h4B);
    endtask

    task automatic t_pd();
        wr(IDX_PD_FUNC, 8'h03);
        for (int p = 1; p < 3; p++) begin
            drive(17'h00F00, {5'h0, p[3:0], 8'h00});
            settle();
            chk({irq[5:4], cap1, cap0}, {p[1:0], p[1:0]});
            chk(pd_oe, 4'h0);
        end
        drive(17'h0, 17'h0);
        wr(IDX_PD_DATA, 8'h00);
        wr(IDX_PD_DIR, 8'h0C);
        tmr[4:3] <= 2'h2;
        wr(IDX_PD_FUNC, 8'h0C);
        settle();
        chk({pd_oe, lvl[11:10]}, 6'h32);
        wr(IDX_PD_FUNC, 8'h00);
        settle();
        chk(lvl[11:10], 2'h0);
    endtask

    // Unmapped, misaligned and write-only places
    task automatic t_bad();
        apb(1'b0, 8'h04, 8'h00);
        chk(erv, 1'b1);
        chk(rdv, 32'h0);
        apb(1'b0, 8'hF1, 8'h00);
        chk(erv, 1'b1);
        chk(rdv, 32'h0);
        apb(1'b0, {IDX_PF_DIR, 2'h0}, 8'h00);
        chk(erv, 1'b0);
        chk(rdv, 32'h0);
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_pf_gpio();
        t_pf_tx();
        t_pf_serial();
        t_pc();
        t_pd();
        t_bad();
        end_of_test();
    end

    // About twenty-five times the cycles the scenarios need
    initial begin
        repeat (4000) @(posedge core_clk);
        err_total++;
        end_of_test();
    end
endmodule
`default_nettype wire
